// *** inc/dfc_defines.svh ***
// constants for the dac feedback connect control block
// assumes inclusion by bare name from package and modules
`ifndef DFC_DEFINES_SVH
`define DFC_DEFINES_SVH
// register indices on the documented register port
`define DFC_IDX_CH0_CTRL 3'h0
`define DFC_IDX_CH1_CTRL 3'h1
`define DFC_IDX_CH0_TRACK 3'h2
`define DFC_IDX_CH1_TRACK 3'h3
`define DFC_IDX_CH0_DELAY 3'h4
`define DFC_IDX_CH1_DELAY 3'h5
`define DFC_IDX_FAULT 3'h6
// control register fields
`define DFC_CODE_LSB 0
`define DFC_CODE_MSB 7
`define DFC_EN_BIT 8
`define DFC_CON_BIT 9
`define DFC_POL_BIT 10
`define DFC_SERVO_BIT 11
// tracking and delay register fields
`define DFC_TRK_EN_BIT 8
`define DFC_DLY_MSB 9
// codes
`define DFC_CODE_MID 8'h80
`define DFC_CODE_MIN 8'h00
`define DFC_CODE_MAX 8'hFF
// reset values
`define DFC_CTRL_RST 16'h0000
`define DFC_TRACK_RST 16'h0000
`define DFC_DELAY_RST 10'h000
// step interval for ramps and delay decrement, in ns
`define DFC_STEP_NS 1000
`define DFC_CLK_NS 4
`define DFC_STEP_CYC ((`DFC_STEP_NS + `DFC_CLK_NS - 1) / `DFC_CLK_NS)
`endif

// *** inc/dfc_pkg.sv ***
// types for the dac feedback connect control block
// assumes dfc_defines.svh is on the include path
package dfc_pkg;
    `include "dfc_defines.svh"
    typedef enum logic [2:0] {
        DFC_IDLE = 3'b000,
        DFC_SOFT = 3'b001,
        DFC_CONN = 3'b011,
        DFC_FAIL = 3'b010,
        DFC_TRK_WAIT = 3'b110,
        DFC_TRK_STEP = 3'b111
    } dfc_state_t;
    typedef struct packed {
        logic servo;
        logic pol;
        logic con;
        logic en;
        logic [7:0] code;
    } dfc_ctrl_t;
    typedef struct packed {
        logic we;
        logic [2:0] idx;
        logic [15:0] wdata;
    } dfc_wr_t;
endpackage

// *** logic/dfc_step_timer.sv ***
// free running step tick generator shared by ramps and delays
// assumes one synchronous clock domain with a clock enable
`timescale 1ns/1ps
`include "dfc_defines.svh"
module dfc_step_timer
    import dfc_pkg::*;
#(
    parameter int PERIOD = `DFC_STEP_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clk_en,
    // tick
    output logic tick
);
    localparam int W = $clog2(PERIOD + 1);
    logic [W-1:0] cnt_reg;

    initial begin
        if (PERIOD < 1) begin
            $error("step period must be at least one cycle");
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= '0;
            tick <= 1'b0;
        end else if (clk_en) begin
            if (cnt_reg == W'(PERIOD - 1)) begin
                cnt_reg <= '0;
                tick <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg + 1'b1;
                tick <= 1'b0;
            end
        end
    end
endmodule

// *** logic/dfc_channel.sv ***
// one channel: connect state machine, dac code, tracking engine
// assumes writes come already decoded for this channel
`timescale 1ns/1ps
`include "dfc_defines.svh"
module dfc_channel
    import dfc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clk_en,
    // decoded writes
    input wire logic ctrl_we,
    input wire logic track_we,
    input wire logic delay_we,
    input wire logic [15:0] wdata,
    // environment
    input wire logic tick,
    input wire logic soft_grant,
    input wire logic match_comparator,
    input wire logic track_lock,
    input wire logic track_start,
    // state
    output logic soft_req,
    output dfc_ctrl_t ctrl_reg,
    output logic [8:0] track_reg,
    output logic [9:0] delay_reg,
    output logic fault_reg,
    output logic connect_reg,
    output dfc_state_t state_reg
);
    logic cmp_ref_reg;
    logic primed_reg;
    logic [7:0] code_d_reg;
    logic settled;
    logic ramp_ok;
    logic blocked;
    logic track_pend;
    dfc_ctrl_t wr;

    assign wr = dfc_ctrl_t'(wdata[11:0]);
    assign track_pend = (state_reg == DFC_TRK_WAIT) ||
                        (state_reg == DFC_TRK_STEP);
    // lock-outs on connect requests and field changes
    assign blocked = (state_reg == DFC_SOFT) || fault_reg ||
                     track_lock || track_pend;
    assign soft_req = (state_reg == DFC_SOFT);
    // comparator only reflects the code once the output register caught up
    assign settled = (code_d_reg == ctrl_reg.code);
    assign ramp_ok = soft_grant && settled;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= DFC_IDLE;
            ctrl_reg <= dfc_ctrl_t'(12'(`DFC_CTRL_RST));
            fault_reg <= 1'b0;
            connect_reg <= 1'b0;
            cmp_ref_reg <= 1'b0;
            primed_reg <= 1'b0;
            code_d_reg <= 8'h00;
            track_reg <= 9'(`DFC_TRACK_RST);
            delay_reg <= `DFC_DELAY_RST;
        end else if (clk_en) begin
            code_d_reg <= ctrl_reg.code;
            if (track_we && !track_lock && !track_pend) begin
                track_reg <= wdata[8:0];
            end
            if (delay_we && !track_pend) begin
                delay_reg <= wdata[`DFC_DLY_MSB:0];
            end
            case (state_reg)
                DFC_IDLE, DFC_FAIL: begin
                    if (ctrl_we && !wr.en) begin
                        // clearing enable ends the fault hold
                        ctrl_reg.en <= 1'b0;
                        ctrl_reg.con <= 1'b0;
                        ctrl_reg.servo <= wr.servo;
                        connect_reg <= 1'b0;
                        fault_reg <= 1'b0;
                        state_reg <= DFC_IDLE;
                    end else if (ctrl_we && !blocked && !ctrl_reg.en) begin
                        ctrl_reg.pol <= wr.pol;
                        ctrl_reg.servo <= wr.servo;
                        ctrl_reg.en <= 1'b1;
                        if (wr.con) begin
                            ctrl_reg.code <= wr.code;
                            ctrl_reg.con <= 1'b1;
                            connect_reg <= 1'b1;
                            fault_reg <= (wr.code == `DFC_CODE_MIN) ||
                                (wr.code == `DFC_CODE_MAX);
                            state_reg <= DFC_CONN;
                        end else begin
                            ctrl_reg.code <= `DFC_CODE_MID;
                            primed_reg <= 1'b0;
                            state_reg <= DFC_SOFT;
                        end
                    end
                end
                DFC_SOFT: begin
                    if (ramp_ok && !primed_reg) begin
                        // first settled sample at mid-scale is the reference
                        cmp_ref_reg <= match_comparator;
                        primed_reg <= 1'b1;
                    end else if (ramp_ok &&
                            match_comparator != cmp_ref_reg) begin
                        ctrl_reg.con <= 1'b1;
                        connect_reg <= 1'b1;
                        state_reg <= DFC_CONN;
                    end else if (ramp_ok && (
                            ctrl_reg.code == `DFC_CODE_MIN ||
                            ctrl_reg.code == `DFC_CODE_MAX)) begin
                        fault_reg <= 1'b1;
                        state_reg <= DFC_FAIL;
                    end else if (ramp_ok && tick) begin
                        // step toward the comparator edge
                        if (match_comparator) begin
                            ctrl_reg.code <= ctrl_reg.code - 1'b1;
                        end else begin
                            ctrl_reg.code <= ctrl_reg.code + 1'b1;
                        end
                    end
                end
                DFC_CONN: begin
                    if (track_start && track_reg[`DFC_TRK_EN_BIT]) begin
                        state_reg <= DFC_TRK_WAIT;
                    end else if (ctrl_we && !wr.en) begin
                        ctrl_reg.en <= 1'b0;
                        ctrl_reg.con <= 1'b0;
                        connect_reg <= 1'b0;
                        fault_reg <= 1'b0;
                        state_reg <= DFC_IDLE;
                    end else if (ctrl_we && wr.con && !track_lock) begin
                        ctrl_reg.pol <= wr.pol;
                        ctrl_reg.servo <= wr.servo;
                        ctrl_reg.code <= wr.code;
                        fault_reg <= fault_reg ||
                            (wr.code == `DFC_CODE_MIN) ||
                            (wr.code == `DFC_CODE_MAX);
                    end
                end
                DFC_TRK_WAIT: begin
                    if (delay_reg == 10'h000) begin
                        state_reg <= DFC_TRK_STEP;
                    end else if (tick) begin
                        delay_reg <= delay_reg - 1'b1;
                    end
                end
                DFC_TRK_STEP: begin
                    if (ctrl_reg.code == track_reg[7:0]) begin
                        track_reg[`DFC_TRK_EN_BIT] <= 1'b0;
                        state_reg <= DFC_CONN;
                    end else if (tick) begin
                        if (ctrl_reg.code < track_reg[7:0]) begin
                            ctrl_reg.code <= ctrl_reg.code + 1'b1;
                        end else begin
                            ctrl_reg.code <= ctrl_reg.code - 1'b1;
                        end
                    end
                end
                default: begin
                    state_reg <= DFC_IDLE;
                end
            endcase
        end
    end

    a_end_fault: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        clk_en && state_reg == DFC_SOFT && ramp_ok && primed_reg &&
        match_comparator == cmp_ref_reg &&
        (ctrl_reg.code == `DFC_CODE_MIN ||
        ctrl_reg.code == `DFC_CODE_MAX) |=>
        fault_reg && !connect_reg && state_reg == DFC_FAIL)
        else $error("end of range did not fault");
endmodule

// *** logic/dfc_top.sv ***
// dac feedback connect control, two channels with soft connect,
// hard connect, reprogram and tracking ramp
// assumes a decoded register port and synchronous inputs
//
// Notes on behaviour
// - tracking steps the code by one toward the target field
// - tracking enable bit gates tracking; upper bits read zero
// - each channel holds a ten bit ramp start delay
// - soft connect ramps until comparator changes; that code is kept
// - output joins only if no dac fault arose on the way
// - soft connect begins at mid-scale, written code ignored
// - comparator trip connects the buffer and sets connected bit
// - code hitting end of range faults and leaves connected low
// - channel 0 is served first when both request soft connect
// - pending or failed soft connect refuses soft requests
// - pending or failed soft connect refuses hard requests
// - tracking pin condition freezes connect and reprogram requests and the tracking field
// - pending tracking refuses soft connect and polarity change
// - pending tracking refuses hard connect and field changes
// - hard connect joins at once with the written code
// - end codes accepted but set the dac fault flag
// - polarity change on a connected channel is accepted
// - clearing connected bit alone does not disconnect
// - stepping starts once the delay counter reaches zero
`timescale 1ns/1ps
`include "dfc_defines.svh"
module dfc_top
    import dfc_pkg::*;
#(
    parameter int STEP_CYC = `DFC_STEP_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clk_en,
    // register port
    input wire dfc_wr_t reg_wr,
    input wire logic [2:0] rd_idx,
    output logic [15:0] rd_data,
    // analogue side
    input wire logic [1:0] match_comparator,
    output logic [1:0] trim_output_oe,
    output logic [7:0] dac_code0,
    output logic [7:0] dac_code1,
    // tracking pins and start, dac fault flags
    input wire logic track_cfg_pin,
    input wire logic [1:0] supply_run,
    input wire logic track_start,
    output logic [1:0] dac_fault
);
    logic tick;
    logic track_lock;
    logic [1:0] soft_req;
    logic [1:0] soft_grant;
    logic [1:0] fault;
    logic [1:0] conn;
    dfc_ctrl_t ctrl [2];
    logic [8:0] track [2];
    logic [9:0] delay [2];
    dfc_state_t st [2];
    logic [15:0] rd_next;

    initial begin
        if (STEP_CYC < 1) begin
            $error("STEP_CYC must be at least one");
        end
    end

    // tracking pin condition
    assign track_lock = track_cfg_pin && (|supply_run);
    // channel 0 wins when both ramp
    assign soft_grant[0] = soft_req[0];
    assign soft_grant[1] = soft_req[1] && !soft_req[0];

    dfc_step_timer #(
        .PERIOD(STEP_CYC)
    ) u_timer (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .tick(tick)
    );

    for (genvar c = 0; c < 2; c++) begin : g_ch
        dfc_channel u_ch (
            .sys_clk(sys_clk),
            .nrst(nrst),
            .clk_en(clk_en),
            .ctrl_we(reg_wr.we && reg_wr.idx == 3'(c)),
            .track_we(reg_wr.we && reg_wr.idx == 3'(c + 2)),
            .delay_we(reg_wr.we && reg_wr.idx == 3'(c + 4)),
            .wdata(reg_wr.wdata),
            .tick(tick),
            .soft_grant(soft_grant[c]),
            .match_comparator(match_comparator[c]),
            .track_lock(track_lock),
            .track_start(track_start),
            .soft_req(soft_req[c]),
            .ctrl_reg(ctrl[c]),
            .track_reg(track[c]),
            .delay_reg(delay[c]),
            .fault_reg(fault[c]),
            .connect_reg(conn[c]),
            .state_reg(st[c])
        );
    end

    // read mux, reserved bits zero
    always_comb begin
        rd_next = 16'h0000;
        case (rd_idx)
            `DFC_IDX_CH0_CTRL: rd_next = {4'h0, ctrl[0]};
            `DFC_IDX_CH1_CTRL: rd_next = {4'h0, ctrl[1]};
            `DFC_IDX_CH0_TRACK: rd_next = {7'h00, track[0]};
            `DFC_IDX_CH1_TRACK: rd_next = {7'h00, track[1]};
            `DFC_IDX_CH0_DELAY: rd_next = {6'h00, delay[0]};
            `DFC_IDX_CH1_DELAY: rd_next = {6'h00, delay[1]};
            `DFC_IDX_FAULT: rd_next = {14'h0000, fault};
            default: rd_next = 16'h0000;
        endcase
    end

    // registered outputs
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rd_data <= 16'h0000;
            trim_output_oe <= 2'b00;
            dac_code0 <= 8'h00;
            dac_code1 <= 8'h00;
            dac_fault <= 2'b00;
        end else if (clk_en) begin
            rd_data <= rd_next;
            trim_output_oe <= conn;
            dac_code0 <= ctrl[0].code;
            dac_code1 <= ctrl[1].code;
            dac_fault <= fault;
        end
    end

    // checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    a_soft_mid: assert property (
        clk_en && st[0] == DFC_IDLE && !track_lock && !fault[0] &&
        !ctrl[0].en && reg_wr.we && reg_wr.idx == 3'h0 &&
        reg_wr.wdata[9:8] == 2'b01 |=> ctrl[0].code == 8'h80)
        else $error("soft connect did not start at mid-scale");
    a_hard_code: assert property (
        clk_en && st[1] == DFC_IDLE && !track_lock && !fault[1] &&
        !ctrl[1].en && reg_wr.we && reg_wr.idx == 3'h1 &&
        reg_wr.wdata[9:8] == 2'b11 |=>
        conn[1] && ctrl[1].code == $past(reg_wr.wdata[7:0]))
        else $error("hard connect did not load written code");
    a_ch_prio: assert property (
        clk_en && soft_req[0] && soft_req[1] |=> $stable(ctrl[1].code))
        else $error("channel 1 served ahead of channel 0");
    a_soft_lock: assert property (
        clk_en && fault[1] && st[1] == DFC_FAIL && reg_wr.we &&
        reg_wr.idx == 3'h1 && reg_wr.wdata[8] |=> $stable(ctrl[1]))
        else $error("failed channel accepted a connect");
    a_track_lock: assert property (
        clk_en && track_lock && st[0] == DFC_CONN && reg_wr.we &&
        reg_wr.idx == 3'h0 && reg_wr.wdata[9:8] == 2'b11 |=>
        $stable(ctrl[0]))
        else $error("connect taken under tracking pin condition");
    a_trk_pol: assert property (
        clk_en && st[1] == DFC_TRK_WAIT |=>
        ctrl[1].pol == $past(ctrl[1].pol))
        else $error("polarity changed while tracking pending");
    a_trk_step: assert property (
        clk_en && st[1] == DFC_TRK_STEP && tick &&
        ctrl[1].code < track[1][7:0] |=> ctrl[1].code ==
        $past(ctrl[1].code) + 8'h01)
        else $error("tracking step not one count up");
    a_dly_zero: assert property (
        clk_en && st[1] == DFC_TRK_WAIT && delay[1] == 10'h000 |=>
        st[1] == DFC_TRK_STEP)
        else $error("stepping not started at zero delay");
    a_con_hold: assert property (
        clk_en && st[0] == DFC_CONN && reg_wr.we && reg_wr.idx == 3'h0 &&
        reg_wr.wdata[9:8] == 2'b01 && !track_start |=> conn[0])
        else $error("clearing connected bit disconnected output");
    a_oe_follow: assert property (
        clk_en && conn[0] |=> trim_output_oe[0])
        else $error("output not joined after connect");
endmodule

// *** test/dfc_node_model.sv ***
// feedback node model: comparator per channel against a trip level
// assumes the bench sets the trip levels; 9'h100 never trips
`timescale 1ns/1ps
module dfc_node_model (
    // dac codes from the block
    input wire logic [7:0] dac_code0,
    input wire logic [7:0] dac_code1,
    // trip levels from the bench
    input wire logic [8:0] trip0,
    input wire logic [8:0] trip1,
    // comparator levels back to the block
    output logic [1:0] match_comparator
);
    // high once the buffered voltage reaches the node voltage
    assign match_comparator[0] = {1'b0, dac_code0} >= trip0;
    assign match_comparator[1] = {1'b0, dac_code1} >= trip1;
endmodule

// *** test/testbench.sv ***
// bench for the dac feedback connect control block
// assumes the node model in test/ and a short step interval
`timescale 1ns/1ps
`include "dfc_defines.svh"
module testbench
    import dfc_pkg::*;
;
    logic sys_clk, nrst, clk_en, track_cfg_pin, track_start;
    logic [1:0] supply_run, match_comparator, trim_output_oe, dac_fault;
    logic [2:0] rd_idx;
    logic [15:0] rd_data, rv;
    logic [7:0] dac_code0, dac_code1;
    logic [8:0] trip0, trip1;
    logic [3:0] flags;
    dfc_wr_t reg_wr;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;

    assign flags = {dac_fault, trim_output_oe};

    dfc_top #(.STEP_CYC(2)) uut (
        .sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
        .reg_wr(reg_wr), .rd_idx(rd_idx), .rd_data(rd_data),
        .match_comparator(match_comparator),
        .trim_output_oe(trim_output_oe),
        .dac_code0(dac_code0), .dac_code1(dac_code1),
        .track_cfg_pin(track_cfg_pin), .supply_run(supply_run),
        .track_start(track_start), .dac_fault(dac_fault)
    );

    dfc_node_model node (
        .dac_code0(dac_code0), .dac_code1(dac_code1),
        .trip0(trip0), .trip1(trip1),
        .match_comparator(match_comparator)
    );

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            test_done();
        end
    end

    task automatic chk(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // control word: pol, con, en, code; servo left off
    function automatic logic [15:0] cw(input logic pol, input logic con,
                                       input logic en, input logic [7:0] c);
        return {5'h00, pol, con, en, c};
    endfunction

    task automatic wr(input logic [2:0] idx, input logic [15:0] d);
        @(posedge sys_clk);
        #1;
        reg_wr = {1'b1, idx, d};
        @(posedge sys_clk);
        #1;
        reg_wr.we = 1'b0;
    endtask

    task automatic rd(input logic [2:0] idx, output logic [15:0] d);
        @(posedge sys_clk);
        #1;
        rd_idx = idx;
        @(posedge sys_clk);
        #1;
        d = rd_data;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wait_flag(input int b, input logic v);
        for (int i = 0; i < 2000 && flags[b] !== v; i++) begin
            @(posedge sys_clk);
            #1;
        end
        chk("status flag", 16'(flags[b]), 16'(v));
    endtask

    task automatic wait_code1(input logic [7:0] v);
        for (int i = 0; i < 2000 && dac_code1 !== v; i++) begin
            @(posedge sys_clk);
            #1;
        end
        chk("code1", 16'(dac_code1), 16'(v));
    endtask

    initial begin
        nrst = 1'b0;
        clk_en = 1'b1;
        track_cfg_pin = 1'b0;
        supply_run = 2'b00;
        track_start = 1'b0;
        reg_wr = '0;
        rd_idx = 3'h0;
        trip0 = 9'h07E;
        trip1 = 9'h100;
        repeat (10) @(posedge sys_clk);
        #1;
        nrst = 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd(3'(i), rv);
            chk("reset value", rv, 16'h0000);
        end
        wr(`DFC_IDX_CH0_TRACK, 16'hFEFF);
        rd(`DFC_IDX_CH0_TRACK, rv);
        chk("track reg", rv, 16'h00FF);
        wr(`DFC_IDX_CH0_DELAY, 16'hFFFF);
        rd(`DFC_IDX_CH0_DELAY, rv);
        chk("delay reg", rv, 16'h03FF);
        $display("test registers done");
        // soft connect on both, hard request refused while ramping
        wr(`DFC_IDX_CH0_CTRL, cw(1'b0, 1'b0, 1'b1, 8'h10));
        wr(`DFC_IDX_CH0_CTRL, cw(1'b0, 1'b1, 1'b1, 8'h11));
        wr(`DFC_IDX_CH1_CTRL, cw(1'b0, 1'b0, 1'b1, 8'h20));
        wait_flag(0, 1'b1);
        chk("code0", 16'(dac_code0), 16'h007D);
        rd(`DFC_IDX_CH0_CTRL, rv);
        chk("ctrl0 con", 16'(rv[9]), 16'h0001);
        wait_flag(3, 1'b1);
        chk("oe1", 16'(trim_output_oe[1]), 16'h0000);
        chk("code1", 16'(dac_code1), 16'h00FF);
        wr(`DFC_IDX_CH1_CTRL, cw(1'b1, 1'b0, 1'b1, 8'h20));
        wr(`DFC_IDX_CH1_CTRL, cw(1'b1, 1'b1, 1'b1, 8'h40));
        cyc(10);
        chk("oe1", 16'(trim_output_oe[1]), 16'h0000);
        chk("code1", 16'(dac_code1), 16'h00FF);
        rd(`DFC_IDX_CH1_CTRL, rv);
        chk("ctrl1 pol", 16'(rv[10]), 16'h0000);
        $display("test soft connect done");
        // reprogram connected channel, new polarity, con cleared alone
        wr(`DFC_IDX_CH0_CTRL, cw(1'b1, 1'b1, 1'b1, 8'h60));
        cyc(4);
        chk("code0", 16'(dac_code0), 16'h0060);
        wr(`DFC_IDX_CH0_CTRL, cw(1'b1, 1'b0, 1'b1, 8'h60));
        cyc(4);
        chk("oe0", 16'(trim_output_oe[0]), 16'h0001);
        rd(`DFC_IDX_CH0_CTRL, rv);
        chk("ctrl0 pol con", 16'(rv[10:9]), 16'h0003);
        $display("test reprogram done");
        // tracking pin lock
        track_cfg_pin = 1'b1;
        supply_run = 2'b10;
        wr(`DFC_IDX_CH0_CTRL, cw(1'b0, 1'b1, 1'b1, 8'h22));
        cyc(6);
        chk("code0", 16'(dac_code0), 16'h0060);
        rd(`DFC_IDX_CH0_CTRL, rv);
        chk("ctrl0 pol", 16'(rv[10]), 16'h0001);
        track_cfg_pin = 1'b0;
        supply_run = 2'b00;
        $display("test lock done");
        // clear the failed channel, hard connect, then track up
        wr(`DFC_IDX_CH1_CTRL, cw(1'b0, 1'b0, 1'b0, 8'hFF));
        wr(`DFC_IDX_CH1_CTRL, cw(1'b0, 1'b1, 1'b1, 8'h40));
        wait_flag(1, 1'b1);
        chk("code1", 16'(dac_code1), 16'h0040);
        wr(`DFC_IDX_CH1_TRACK, 16'h0144);
        wr(`DFC_IDX_CH1_DELAY, 16'h0003);
        @(posedge sys_clk);
        #1;
        track_start = 1'b1;
        @(posedge sys_clk);
        #1;
        track_start = 1'b0;
        wr(`DFC_IDX_CH1_CTRL, cw(1'b1, 1'b1, 1'b1, 8'h10));
        rd(`DFC_IDX_CH1_CTRL, rv);
        chk("ctrl1 pol", 16'(rv[10]), 16'h0000);
        wait_code1(8'h44);
        cyc(10);
        chk("code1", 16'(dac_code1), 16'h0044);
        chk("code0", 16'(dac_code0), 16'h0060);
        $display("test tracking done");
        // end code on reprogram is taken but faults
        wr(`DFC_IDX_CH1_CTRL, cw(1'b0, 1'b1, 1'b1, 8'h00));
        wait_flag(3, 1'b1);
        chk("code1", 16'(dac_code1), 16'h0000);
        chk("oe1", 16'(trim_output_oe[1]), 16'h0001);
        $display("test end code done");
        test_done();
    end
endmodule
